// ==== spp_protect.sv ====
/*
 * Sector and password protection core: protection config bits, global
 * freeze flag, nonvolatile sector locks and the program/erase gate.
 * Assumes commands arrive already decoded from the serial framing, the
 * stored password is presented on a port, and FACTORY_RSTN_I only fires
 * on a blank device (nonvolatile state survives RSTN_I).
 */
// How it works
// R1: 16-bit protection config; only bits 2 and 1 do anything.
// R2: volatile freeze flag shields every nonvolatile sector lock.
// R3: one nonvolatile lock per sector, held until erased back to 1.
// R4: one volatile lock per sector, cleared by every reset.
// R5: first and last sectors get volatile locks per 4KB subsector.
// R6: bit 2 defaults 1; at 0 password mode is on, password frozen.
// R7: bit 1 defaults 1; at 0 password mode is barred forever.
// R8: bits 2 and 1 are one-time and at most one may be 0.
// R9: host should fix one mode bit early in first programming.
// R10: host programs and verifies password before enabling password mode.
// R11: in password mode, freeze rises only with the right password.
// R12: nonvolatile locks writable in either mode, subject to freeze.
// R13: host sets password bit before the sector bit.
// R14: a blank device has every sector unlocked.
// R15: 8-bit freeze register, bit 0 flag, 1 allows lock changes.
// R16: host clears freeze only after lock bits are configured.
// R17: freeze read command returns the current flag.
// R18: in password mode the flag comes up locked after every reset.
// R19: correct unlock password sets the flag to 1.
// R20: freeze write command clears the flag to 0.
// R21: nonvolatile lock 0 blocks program and erase of its sector.
// R22: volatile lock 1 blocks program and erase of its sector.
// R23: program/erase runs only when neither lock says locked.
`timescale 1ns/1ps
module spp_protect (
    // clock and resets
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic FACTORY_RSTN_I,
    // command port
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    input wire spp_pkg::spp_cmd_t CMD_OP_I,
    input wire logic [spp_pkg::SEC_W-1:0] CMD_SECTOR_I,
    input wire logic [spp_pkg::SUB_W-1:0] CMD_SUB_I,
    input wire logic [spp_pkg::SPR_W-1:0] CMD_DATA_I,
    input wire logic [spp_pkg::PW_W-1:0] CMD_PASSWORD_I,
    // answer
    output logic RESP_VALID_O,
    output logic RESP_OK_O,
    output logic [spp_pkg::RESP_W-1:0] RESP_DATA_O,
    // password store
    input wire logic [spp_pkg::PW_W-1:0] STORED_PASSWORD_I,
    output logic PW_ACCESS_EN_O,
    // array program/erase gate
    input wire logic ARRAY_REQ_I,
    input wire logic [spp_pkg::SEC_W-1:0] ARRAY_SECTOR_I,
    input wire logic [spp_pkg::SUB_W-1:0] ARRAY_SUB_I,
    output logic ARRAY_GRANT_O,
    output logic ARRAY_DENY_O,
    // status
    output logic FREEZE_O
);

    typedef enum logic {ST_IDLE, ST_EXEC} spp_state_t;

    spp_state_t state_ff;
    spp_pkg::spp_cmd_t op_ff;
    logic [spp_pkg::SEC_W-1:0] sec_ff;
    logic [spp_pkg::SUB_W-1:0] sub_ff;
    logic [spp_pkg::SPR_W-1:0] data_ff;
    logic [spp_pkg::PW_W-1:0] pw_ff;

    logic pw_off_ff;
    logic pw_barred_n_ff;
    logic nv_lock_ff [spp_pkg::SECTORS];
    logic freeze_ff;
    logic pw_ok_ff;

    logic exec;
    logic freeze_eff;
    logic pw_match;
    logic spr_wr_ok;
    logic nxt_ok;
    logic [spp_pkg::RESP_W-1:0] nxt_data;

    spp_vlock_if vl();

    spp_vlock u_vlock (
        .clock_i(CLOCK_I),
        .rstn_i(RSTN_I),
        .vl(vl)
    );

    ////////////////////////////////////////////////////////////////////////
    // command sequencing: take in idle, act one cycle later

    assign CMD_READY_O = (state_ff == ST_IDLE);
    assign exec = (state_ff == ST_EXEC);

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (CMD_VALID_I) begin
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            op_ff <= spp_pkg::CMD_RD_SPR;
            sec_ff <= '0;
            sub_ff <= '0;
            data_ff <= '0;
            pw_ff <= '0;
        end else if (CMD_VALID_I && CMD_READY_O) begin
            op_ff <= CMD_OP_I;
            sec_ff <= CMD_SECTOR_I;
            sub_ff <= CMD_SUB_I;
            data_ff <= CMD_DATA_I;
            pw_ff <= CMD_PASSWORD_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection config bits: nonvolatile, program only 1 -> 0

    // refuse a 0 on both bits, or a 0 on one once the other is 0
    assign spr_wr_ok = !(!data_ff[spp_pkg::SPR_PW_BIT]
                         && !data_ff[spp_pkg::SPR_SEC_BIT])
                    && !(!data_ff[spp_pkg::SPR_PW_BIT] && !pw_barred_n_ff)
                    && !(!data_ff[spp_pkg::SPR_SEC_BIT] && !pw_off_ff);

    always_ff @(posedge CLOCK_I or negedge FACTORY_RSTN_I) begin
        if (!FACTORY_RSTN_I) begin
            pw_off_ff <= spp_pkg::SPR_RESET[spp_pkg::SPR_PW_BIT]; // [R6]
            pw_barred_n_ff <= spp_pkg::SPR_RESET[spp_pkg::SPR_SEC_BIT]; // [R7]
        end else if (exec && op_ff == spp_pkg::CMD_WR_SPR && spr_wr_ok) begin
            // [R1] [R8] no command returns a bit to 1; only FACTORY_RSTN_I does
            if (!data_ff[spp_pkg::SPR_PW_BIT]) begin
                pw_off_ff <= 1'b0; // [R6]
            end
            if (!data_ff[spp_pkg::SPR_SEC_BIT]) begin
                pw_barred_n_ff <= 1'b0; // [R7]
            end
        end
    end

    // password may be read or changed only until password mode is on
    assign PW_ACCESS_EN_O = pw_off_ff; // [R6]

    ////////////////////////////////////////////////////////////////////////
    // global freeze flag

    assign pw_match = (pw_ff == STORED_PASSWORD_I);

    // pw_ok drops on every reset, so password mode comes up frozen
    assign freeze_eff = freeze_ff && (pw_off_ff || pw_ok_ff); // [R18]
    assign FREEZE_O = freeze_eff;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            freeze_ff <= spp_pkg::FRZ_RESET; // [R15]
            pw_ok_ff <= 1'b0; // [R18]
        end else if (exec && op_ff == spp_pkg::CMD_WR_FRZ) begin
            freeze_ff <= 1'b0; // [R20]
            pw_ok_ff <= 1'b0;
        end else if (exec && op_ff == spp_pkg::CMD_UNLOCK_PW
                     && (pw_off_ff || pw_match)) begin
            freeze_ff <= 1'b1; // [R19] [R11]
            pw_ok_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile sector locks, whole-sector only

    always_ff @(posedge CLOCK_I or negedge FACTORY_RSTN_I) begin
        if (!FACTORY_RSTN_I) begin
            for (int i = 0; i < spp_pkg::SECTORS; i++) begin
                nv_lock_ff[i] <= spp_pkg::NVL_UNLOCKED; // [R14]
            end
        end else if (exec && freeze_eff) begin // [R2] [R12]
            if (op_ff == spp_pkg::CMD_WR_NVL) begin
                nv_lock_ff[sec_ff] <= spp_pkg::NVL_LOCKED; // [R3]
            end else if (op_ff == spp_pkg::CMD_ERASE_NVL) begin
                for (int i = 0; i < spp_pkg::SECTORS; i++) begin
                    nv_lock_ff[i] <= spp_pkg::NVL_UNLOCKED; // [R3]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // volatile lock store hookup

    assign vl.wr_en = exec && (op_ff == spp_pkg::CMD_WR_VL); // [R4]
    assign vl.wr_sec = sec_ff;
    assign vl.wr_sub = sub_ff;
    assign vl.wr_val = data_ff[0];
    assign vl.rd_sec = sec_ff;
    assign vl.rd_sub = sub_ff;
    assign vl.chk_sec = ARRAY_SECTOR_I;
    assign vl.chk_sub = ARRAY_SUB_I;

    ////////////////////////////////////////////////////////////////////////
    // answer of the executing command

    always_comb begin
        nxt_ok = 1'b1;
        nxt_data = '0;
        unique case (op_ff)
            spp_pkg::CMD_RD_SPR: begin
                nxt_data = {spp_pkg::SPR_RESV_HI, pw_off_ff, pw_barred_n_ff,
                            spp_pkg::SPR_RESV_LO}; // [R1]
            end
            spp_pkg::CMD_WR_SPR: begin
                nxt_ok = spr_wr_ok; // [R8]
            end
            spp_pkg::CMD_RD_FRZ: begin
                nxt_data = {8'h00, spp_pkg::FRZ_RESV, freeze_eff}; // [R17]
            end
            spp_pkg::CMD_UNLOCK_PW: begin
                nxt_ok = pw_off_ff || pw_match; // [R11]
            end
            spp_pkg::CMD_RD_NVL: begin
                nxt_data = {15'h0000, nv_lock_ff[sec_ff]};
            end
            spp_pkg::CMD_WR_NVL, spp_pkg::CMD_ERASE_NVL: begin
                nxt_ok = freeze_eff; // [R2]
            end
            spp_pkg::CMD_RD_VL: begin
                nxt_data = {15'h0000, vl.rd_lock};
            end
            default: begin
                nxt_ok = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RESP_VALID_O <= 1'b0;
            RESP_OK_O <= 1'b0;
            RESP_DATA_O <= '0;
        end else begin
            RESP_VALID_O <= exec;
            if (exec) begin
                RESP_OK_O <= nxt_ok;
                RESP_DATA_O <= nxt_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program/erase gate, answered the cycle after the request

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ARRAY_GRANT_O <= 1'b0;
            ARRAY_DENY_O <= 1'b0;
        end else begin
            // [R21] [R22] [R23]
            ARRAY_DENY_O <= ARRAY_REQ_I
                && (nv_lock_ff[ARRAY_SECTOR_I] == spp_pkg::NVL_LOCKED
                    || vl.chk_lock == spp_pkg::VL_LOCKED);
            ARRAY_GRANT_O <= ARRAY_REQ_I
                && nv_lock_ff[ARRAY_SECTOR_I] == spp_pkg::NVL_UNLOCKED
                && vl.chk_lock == spp_pkg::VL_UNLOCKED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I || !FACTORY_RSTN_I);

    a_spr_exclusive: assert property ( // [R8]
        pw_off_ff || pw_barred_n_ff)
        else $error("both protection mode bits at 0");

    a_spr_one_time: assert property ( // [R6]
        !pw_off_ff |=> !pw_off_ff && !PW_ACCESS_EN_O)
        else $error("password mode bit returned to 1");

    a_freeze_clear: assert property ( // [R20]
        exec && op_ff == spp_pkg::CMD_WR_FRZ |=> !FREEZE_O [*2])
        else $error("freeze write did not clear flag");

    a_unlock_wrong: assert property ( // [R11]
        exec && op_ff == spp_pkg::CMD_UNLOCK_PW && !pw_off_ff && !pw_match
        && !freeze_eff |=> !FREEZE_O && !RESP_OK_O)
        else $error("freeze rose without password");

    a_unlock_right: assert property ( // [R19]
        exec && op_ff == spp_pkg::CMD_UNLOCK_PW && pw_match
        |=> FREEZE_O && RESP_OK_O)
        else $error("correct password did not set flag");

    a_freeze_locked: assert property ( // [R18]
        !pw_off_ff && !pw_ok_ff |-> !FREEZE_O)
        else $error("flag open in password mode without unlock");

    a_nv_frozen: assert property ( // [R2]
        exec && !freeze_eff && op_ff == spp_pkg::CMD_WR_NVL
        |=> $stable(nv_lock_ff[sec_ff]) && !RESP_OK_O)
        else $error("nonvolatile lock changed while frozen");

    a_gate_deny: assert property ( // [R23]
        ARRAY_REQ_I && (!nv_lock_ff[ARRAY_SECTOR_I] || vl.chk_lock)
        |=> ARRAY_DENY_O && !ARRAY_GRANT_O)
        else $error("locked sector was granted");

    a_freeze_read: assert property ( // [R17]
        CMD_VALID_I && CMD_READY_O && CMD_OP_I == spp_pkg::CMD_RD_FRZ
        && $stable(freeze_eff)
        |=> !CMD_READY_O ##1 RESP_VALID_O
            && RESP_DATA_O == {15'h0000, $past(freeze_eff)})
        else $error("freeze read answer wrong or late");

    c_unlock_ok: cover property (
        exec && op_ff == spp_pkg::CMD_UNLOCK_PW && !pw_off_ff && pw_match);
    c_nv_lock: cover property (
        exec && op_ff == spp_pkg::CMD_WR_NVL && freeze_eff);
    c_gate_deny: cover property (ARRAY_DENY_O);
    c_pw_enable: cover property ($fell(pw_off_ff));

endmodule : spp_protect

// ==== spp_pkg.sv ====
/*
 * Shared constants, command codes and sector helpers for the sector and
 * password protection block.
 * Assumes a device of 512 uniform 64KB sectors, each of 16 4KB subsectors.
 */
package spp_pkg;

    localparam int SECTORS = 512;
    localparam int SEC_W = 9;
    localparam int SUBS = 16;
    localparam int SUB_W = 4;
    localparam int PW_W = 64;
    localparam int SPR_W = 16;
    localparam int FRZ_W = 8;
    localparam int RESP_W = 16;

    // sector protection config: only two live bits
    localparam int SPR_PW_BIT = 2;
    localparam int SPR_SEC_BIT = 1;
    localparam logic [SPR_W-1:0] SPR_RESET = 16'hffff;
    localparam logic [12:0] SPR_RESV_HI = 13'h1fff;
    localparam logic SPR_RESV_LO = 1'b1;

    // freeze flag: bits 7:1 read zero
    localparam logic [FRZ_W-2:0] FRZ_RESV = 7'h00;
    localparam logic FRZ_RESET = 1'b1;

    localparam logic NVL_UNLOCKED = 1'b1;
    localparam logic NVL_LOCKED = 1'b0;
    localparam logic VL_UNLOCKED = 1'b0;
    localparam logic VL_LOCKED = 1'b1;

    localparam logic [SEC_W-1:0] SEC_FIRST = 9'h000;
    localparam logic [SEC_W-1:0] SEC_LAST = 9'h1ff;

    typedef enum logic [3:0] {
        CMD_RD_SPR,
        CMD_WR_SPR,
        CMD_RD_FRZ,
        CMD_WR_FRZ,
        CMD_UNLOCK_PW,
        CMD_RD_NVL,
        CMD_WR_NVL,
        CMD_ERASE_NVL,
        CMD_RD_VL,
        CMD_WR_VL
    } spp_cmd_t;

    // first and last sectors carry per-subsector volatile locks
    function automatic logic is_edge_sector(input logic [SEC_W-1:0] sec);
        is_edge_sector = (sec == SEC_FIRST) || (sec == SEC_LAST);
    endfunction : is_edge_sector

endpackage : spp_pkg

// ==== spp_vlock_if.sv ====
/*
 * Carrier between the protection core and its volatile lock store.
 * Assumes one clock; lookups are combinational.
 */
`timescale 1ns/1ps
interface spp_vlock_if;
    logic wr_en;
    logic [spp_pkg::SEC_W-1:0] wr_sec;
    logic [spp_pkg::SUB_W-1:0] wr_sub;
    logic wr_val;
    logic [spp_pkg::SEC_W-1:0] rd_sec;
    logic [spp_pkg::SUB_W-1:0] rd_sub;
    logic rd_lock;
    logic [spp_pkg::SEC_W-1:0] chk_sec;
    logic [spp_pkg::SUB_W-1:0] chk_sub;
    logic chk_lock;

    modport store (
        input wr_en, wr_sec, wr_sub, wr_val, rd_sec, rd_sub, chk_sec, chk_sub,
        output rd_lock, chk_lock
    );
    modport user (
        output wr_en, wr_sec, wr_sub, wr_val, rd_sec, rd_sub, chk_sec,
        output chk_sub,
        input rd_lock, chk_lock
    );
endinterface : spp_vlock_if

// ==== spp_vlock.sv ====
/*
 * Volatile lock bits: one per sector, one per 4KB subsector in the first
 * and last sectors.
 * Assumes the device reset clears them all, as power loss would.
 */
`timescale 1ns/1ps
module spp_vlock (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // core side
    spp_vlock_if.store vl
);

    logic sec_lock_ff [spp_pkg::SECTORS];
    logic sub_lock_ff [2][spp_pkg::SUBS];

    function automatic logic lookup(input logic [spp_pkg::SEC_W-1:0] sec,
                                    input logic [spp_pkg::SUB_W-1:0] sub);
        if (spp_pkg::is_edge_sector(sec)) begin
            lookup = sub_lock_ff[sec == spp_pkg::SEC_LAST][sub];
        end else begin
            lookup = sec_lock_ff[sec];
        end
    endfunction : lookup

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < spp_pkg::SECTORS; i++) begin
                sec_lock_ff[i] <= spp_pkg::VL_UNLOCKED; // [R4] [R14]
            end
            for (int i = 0; i < spp_pkg::SUBS; i++) begin
                sub_lock_ff[0][i] <= spp_pkg::VL_UNLOCKED; // [R4]
                sub_lock_ff[1][i] <= spp_pkg::VL_UNLOCKED; // [R4]
            end
        end else if (vl.wr_en) begin
            if (spp_pkg::is_edge_sector(vl.wr_sec)) begin
                // [R5]
                sub_lock_ff[vl.wr_sec == spp_pkg::SEC_LAST][vl.wr_sub] <=
                    vl.wr_val;
            end else begin
                sec_lock_ff[vl.wr_sec] <= vl.wr_val;
            end
        end
    end

    // a plain assign would not wake on lock writes read inside lookup
    always_comb begin
        vl.rd_lock = lookup(vl.rd_sec, vl.rd_sub);
        vl.chk_lock = lookup(vl.chk_sec, vl.chk_sub); // [R22]
    end

    ////////////////////////////////////////////////////////////////////////
    a_vlock_write: assert property ( // [R22]
        @(posedge clock_i) disable iff (!rstn_i)
        vl.wr_en |=> lookup($past(vl.wr_sec), $past(vl.wr_sub))
                     == $past(vl.wr_val))
        else $error("volatile lock write not stored");

endmodule : spp_vlock

// ==== spp_host_model.sv ====
/*
 * Host controller model: issues decoded protection commands, one at a
 * time, on the command port of the protection block.
 * Assumes the block answers one edge after it takes a command.
 */
`timescale 1ns/1ps
module spp_host_model (
    // clock
    input wire logic clock_i,
    // command port
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output spp_pkg::spp_cmd_t cmd_op_o,
    output logic [spp_pkg::SEC_W-1:0] cmd_sector_o,
    output logic [spp_pkg::SUB_W-1:0] cmd_sub_o,
    output logic [spp_pkg::SPR_W-1:0] cmd_data_o,
    output logic [spp_pkg::PW_W-1:0] cmd_password_o,
    // answer
    input wire logic resp_valid_i,
    input wire logic resp_ok_i,
    input wire logic [spp_pkg::RESP_W-1:0] resp_data_i
);
    // set once the block fails to take or answer a command
    logic tmo;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o = spp_pkg::CMD_RD_SPR;
        cmd_sector_o = 9'h000;
        cmd_sub_o = 4'h0;
        cmd_data_o = 16'hffff;
        cmd_password_o = 64'h0;
        tmo = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // callers keep the host order: password set first, mode fixed early,
    // password bit before sector bit, freeze only after locks
    task automatic cmd(input spp_pkg::spp_cmd_t op,
        input logic [spp_pkg::SEC_W-1:0] sec,
        input logic [spp_pkg::SUB_W-1:0] sub,
        input logic [spp_pkg::SPR_W-1:0] d,
        input logic [spp_pkg::PW_W-1:0] pw,
        output logic ok, output logic [spp_pkg::RESP_W-1:0] rd);
        int n;
        n = 0;
        cmd_op_o = op;
        cmd_sector_o = sec;
        cmd_sub_o = sub;
        cmd_data_o = d;
        cmd_password_o = pw;
        cmd_valid_o = 1'b1;
        while (cmd_ready_i !== 1'b1 && n < 8) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (cmd_ready_i !== 1'b1) begin
            tmo = 1'b1;
        end
        @(posedge clock_i);
        #1;
        cmd_valid_o = 1'b0;
        // released lines carry garbage, never the last value
        cmd_op_o = spp_pkg::spp_cmd_t'(~op);
        cmd_sector_o = ~sec;
        cmd_sub_o = ~sub;
        cmd_data_o = ~d;
        cmd_password_o = ~pw;
        n = 0;
        while (resp_valid_i !== 1'b1 && n < 4) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (resp_valid_i !== 1'b1) begin
            tmo = 1'b1;
        end
        ok = resp_ok_i;
        rd = resp_data_i;
    endtask : cmd
endmodule : spp_host_model

// ==== tb_top.sv ====
/*
 * Self-checking bench for the protection core: commands through the host
 * model, program/erase checks on the array gate.
 * Assumes both resets are driven here and a fixed stored password.
 */
`timescale 1ns/1ps
module tb_top;
    localparam logic [63:0] PW_GOOD = 64'h5a5a_0f0f_c3c3_9696;
    localparam logic [63:0] PW_BAD = 64'h5a5a_0f0f_c3c3_9697;
    logic CLOCK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic FACTORY_RSTN_I = 1'b0;
    logic cmd_valid, cmd_ready, resp_valid, resp_ok, pw_en, freeze;
    spp_pkg::spp_cmd_t cmd_op;
    logic [8:0] cmd_sec;
    logic [3:0] cmd_sub;
    logic [15:0] cmd_data, resp_data, rd;
    logic [63:0] cmd_pw;
    logic ARRAY_REQ_I = 1'b0;
    logic [8:0] ARRAY_SECTOR_I = 9'h000;
    logic [3:0] ARRAY_SUB_I = 4'h0;
    logic grant, deny, ok;
    int failures = 0;
    int n_tests = 0;

    always #10 CLOCK_I = ~CLOCK_I;

    spp_protect spp_protect_i (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
        .FACTORY_RSTN_I(FACTORY_RSTN_I), .CMD_VALID_I(cmd_valid),
        .CMD_READY_O(cmd_ready), .CMD_OP_I(cmd_op),
        .CMD_SECTOR_I(cmd_sec), .CMD_SUB_I(cmd_sub),
        .CMD_DATA_I(cmd_data), .CMD_PASSWORD_I(cmd_pw),
        .RESP_VALID_O(resp_valid), .RESP_OK_O(resp_ok),
        .RESP_DATA_O(resp_data), .STORED_PASSWORD_I(PW_GOOD),
        .PW_ACCESS_EN_O(pw_en), .ARRAY_REQ_I(ARRAY_REQ_I),
        .ARRAY_SECTOR_I(ARRAY_SECTOR_I), .ARRAY_SUB_I(ARRAY_SUB_I),
        .ARRAY_GRANT_O(grant), .ARRAY_DENY_O(deny), .FREEZE_O(freeze));

    spp_host_model spp_host_model_i (.clock_i(CLOCK_I),
        .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
        .cmd_op_o(cmd_op), .cmd_sector_o(cmd_sec), .cmd_sub_o(cmd_sub),
        .cmd_data_o(cmd_data), .cmd_password_o(cmd_pw),
        .resp_valid_i(resp_valid), .resp_ok_i(resp_ok),
        .resp_data_i(resp_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input spp_pkg::spp_cmd_t op, input logic [8:0] sec,
        input logic [3:0] sub, input logic [15:0] d,
        input logic [63:0] pw, input logic exp_ok);
        spp_host_model_i.cmd(op, sec, sub, d, pw, ok, rd);
        if (spp_host_model_i.tmo) begin
            failures++;
            print_verdict();
        end
        chk({15'h0, ok}, {15'h0, exp_ok});
    endtask : wr

    task automatic rdc(input spp_pkg::spp_cmd_t op, input logic [8:0] sec,
        input logic [3:0] sub, input logic [15:0] exp);
        wr(op, sec, sub, 16'h0000, 64'h0, 1'b1);
        chk(rd, exp);
    endtask : rdc

    // one request cycle; the answer pulse stands only in the next cycle
    task automatic arr(input logic [8:0] sec, input logic [3:0] sub,
        input logic g);
        ARRAY_SECTOR_I = sec;
        ARRAY_SUB_I = sub;
        ARRAY_REQ_I = 1'b1;
        @(posedge CLOCK_I);
        #1;
        ARRAY_REQ_I = 1'b0;
        ARRAY_SECTOR_I = ~sec;
        ARRAY_SUB_I = ~sub;
        chk({14'h0000, grant, deny}, {14'h0000, g, ~g});
        @(posedge CLOCK_I);
        #1;
    endtask : arr

    task automatic rst(input logic fac);
        RSTN_I = 1'b0;
        FACTORY_RSTN_I = ~fac;
        repeat (2) @(posedge CLOCK_I);
        #1;
        RSTN_I = 1'b1;
        FACTORY_RSTN_I = 1'b1;
    endtask : rst

    ////////////////////////////////////////////////////////////////////////
    task automatic t_blank();
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hffff);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0001);
        chk({15'h0, freeze}, 16'h0001);
        chk({15'h0, pw_en}, 16'h0001);
        rdc(spp_pkg::CMD_RD_NVL, 9'h1ff, 4'h0, 16'h0001);
        rdc(spp_pkg::CMD_RD_VL, 9'h000, 4'hf, 16'h0000);
        arr(9'h123, 4'h0, 1'b1);
        $display("done blank");
    endtask : t_blank

    task automatic t_nvlock();
        wr(spp_pkg::CMD_WR_NVL, 9'h005, 4'h0, 16'h0, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_NVL, 9'h005, 4'h0, 16'h0000);
        arr(9'h005, 4'h0, 1'b0);
        arr(9'h006, 4'h0, 1'b1);
        rst(1'b0);
        rdc(spp_pkg::CMD_RD_NVL, 9'h005, 4'h0, 16'h0000);
        arr(9'h005, 4'h0, 1'b0);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_NVL, 9'h005, 4'h0, 16'h0001);
        arr(9'h005, 4'h0, 1'b1);
        $display("done nvlock");
    endtask : t_nvlock

    task automatic t_vlock();
        wr(spp_pkg::CMD_WR_VL, 9'h007, 4'h0, 16'h1, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_VL, 9'h007, 4'h0, 16'h0001);
        arr(9'h007, 4'h0, 1'b0);
        wr(spp_pkg::CMD_WR_VL, 9'h000, 4'h3, 16'h1, 64'h0, 1'b1);
        arr(9'h000, 4'h3, 1'b0);
        arr(9'h000, 4'h4, 1'b1);
        wr(spp_pkg::CMD_WR_VL, 9'h1ff, 4'hf, 16'h1, 64'h0, 1'b1);
        arr(9'h1ff, 4'hf, 1'b0);
        arr(9'h1ff, 4'he, 1'b1);
        rst(1'b0);
        arr(9'h007, 4'h0, 1'b1);
        arr(9'h000, 4'h3, 1'b1);
        rdc(spp_pkg::CMD_RD_VL, 9'h1ff, 4'hf, 16'h0000);
        $display("done vlock");
    endtask : t_vlock

    task automatic t_freeze();
        wr(spp_pkg::CMD_WR_FRZ, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0000);
        chk({15'h0, freeze}, 16'h0000);
        wr(spp_pkg::CMD_WR_NVL, 9'h009, 4'h0, 16'h0, 64'h0, 1'b0);
        rdc(spp_pkg::CMD_RD_NVL, 9'h009, 4'h0, 16'h0001);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b0);
        wr(spp_pkg::CMD_UNLOCK_PW, 9'h0, 4'h0, 16'h0, PW_BAD, 1'b1);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0001);
        $display("done freeze");
    endtask : t_freeze

    task automatic t_pwmode();
        wr(spp_pkg::CMD_WR_SPR, 9'h0, 4'h0, 16'hfff9, 64'h0, 1'b0);
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hffff);
        wr(spp_pkg::CMD_WR_NVL, 9'h009, 4'h0, 16'h0, 64'h0, 1'b1);
        wr(spp_pkg::CMD_WR_SPR, 9'h0, 4'h0, 16'hfffb, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hfffb);
        chk({15'h0, pw_en}, 16'h0000);
        wr(spp_pkg::CMD_WR_FRZ, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        chk({15'h0, freeze}, 16'h0000);
        wr(spp_pkg::CMD_WR_SPR, 9'h0, 4'h0, 16'hfffd, 64'h0, 1'b0);
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hfffb);
        wr(spp_pkg::CMD_UNLOCK_PW, 9'h0, 4'h0, 16'h0, PW_BAD, 1'b0);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0000);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b0);
        wr(spp_pkg::CMD_UNLOCK_PW, 9'h0, 4'h0, 16'h0, PW_GOOD, 1'b1);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0001);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        arr(9'h009, 4'h0, 1'b1);
        rst(1'b0);
        chk({15'h0, freeze}, 16'h0000);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0000);
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hfffb);
        $display("done pwmode");
    endtask : t_pwmode

    task automatic t_secmode();
        rst(1'b1);
        wr(spp_pkg::CMD_WR_SPR, 9'h0, 4'h0, 16'hfffd, 64'h0, 1'b1);
        rdc(spp_pkg::CMD_RD_SPR, 9'h000, 4'h0, 16'hfffd);
        wr(spp_pkg::CMD_WR_SPR, 9'h0, 4'h0, 16'hfffb, 64'h0, 1'b0);
        wr(spp_pkg::CMD_WR_NVL, 9'h020, 4'h0, 16'h0, 64'h0, 1'b1);
        arr(9'h020, 4'h0, 1'b0);
        wr(spp_pkg::CMD_WR_FRZ, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b0);
        rst(1'b0);
        rdc(spp_pkg::CMD_RD_FRZ, 9'h000, 4'h0, 16'h0001);
        wr(spp_pkg::CMD_ERASE_NVL, 9'h0, 4'h0, 16'h0, 64'h0, 1'b1);
        $display("done secmode");
    endtask : t_secmode

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge CLOCK_I);
        #1;
        RSTN_I = 1'b1;
        FACTORY_RSTN_I = 1'b1;
        t_blank();
        t_nvlock();
        t_vlock();
        t_freeze();
        t_pwmode();
        t_secmode();
        print_verdict();
    end
endmodule : tb_top
